// >>> qdac_pkg.sv
/*
  Shared constants and types of the quad converter control block:
  command codes, frame field positions, clear codes and reset values.
  Assumes every file refers to these names as qdac_pkg::name.
*/
package qdac_pkg;

  // ---------------------------------------------------------------
  // Frame layout
  // ---------------------------------------------------------------
  localparam int FRAME_BITS = 32;
  localparam logic [5:0] FRAME_LAST_INDEX = 6'h1f;
  localparam logic [5:0] FRAME_FULL_COUNT = 6'h20;
  localparam int POWER_MODE_HI_POS = 9;
  localparam int POWER_MODE_LO_POS = 8;
  localparam int CHAIN_ENABLE_POS = 1;
  localparam int REF_ENABLE_POS = 0;
  localparam int CLEAR_CODE_HI_POS = 1;
  localparam int CLEAR_CODE_LO_POS = 0;
  localparam int CHAN_SEL_HI_POS = 3;
  localparam int CHAN_SEL_LO_POS = 0;

  // ---------------------------------------------------------------
  // Command and address codes
  // ---------------------------------------------------------------
  localparam logic [3:0] CMD_WRITE_INPUT = 4'h0;
  localparam logic [3:0] CMD_UPDATE_DAC = 4'h1;
  localparam logic [3:0] CMD_WRITE_UPDATE_ONE = 4'h2;
  localparam logic [3:0] CMD_WRITE_UPDATE_ALL = 4'h3;
  localparam logic [3:0] CMD_POWER_MODE = 4'h4;
  localparam logic [3:0] CMD_LOAD_CLEAR_CODE = 4'h5;
  localparam logic [3:0] CMD_LOAD_UPDATE_MASK = 4'h6;
  localparam logic [3:0] CMD_SOFT_RESET = 4'h7;
  localparam logic [3:0] CMD_SETUP = 4'h8;
  localparam logic [3:0] ADDR_ALL = 4'hf;

  // ---------------------------------------------------------------
  // Clear codes and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] CLEAR_SEL_ZERO = 2'h0;
  localparam logic [1:0] CLEAR_SEL_MID = 2'h1;
  localparam logic [1:0] CLEAR_SEL_FULL = 2'h2;
  localparam logic [1:0] CLEAR_SEL_NOP = 2'h3;
  localparam logic [15:0] CODE_ZERO = 16'h0000;
  localparam logic [15:0] CODE_MID = 16'h8000;
  localparam logic [15:0] CODE_FULL = 16'hffff;
  localparam logic [15:0] RESET_CODE = 16'h0000;
  localparam logic [3:0] RESET_UPDATE_MASK = 4'h0;
  localparam logic [1:0] RESET_CLEAR_SEL = 2'h0;
  localparam logic [1:0] RESET_SETUP = 2'h0;
  localparam logic [1:0] POWER_NORMAL = 2'h0;

  // Pin bundle passed through the synchroniser
  typedef struct packed {
    logic sclk;
    logic syncN;
    logic din;
    logic asyncClearN;
    logic loadOutputsN;
  } qdac_pins_s;

  // Decoded view of one command frame
  typedef struct packed {
    logic [3:0] lead;
    logic [3:0] cmd;
    logic [3:0] addr;
    logic [15:0] data;
    logic [3:0] tail;
  } qdac_frame_s;

endpackage : qdac_pkg

// >>> qdac_pin_sync.sv
/*
  Two flip-flop synchroniser for a bundle of pin inputs.
  Assumes the inputs are asynchronous to clk; only the second stage is output.
*/
`timescale 1ns/1ps
module qdac_pin_sync #(
  parameter int WIDTH = 5
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] pinsIn,
  input wire logic [WIDTH-1:0] resetValue,
  output logic [WIDTH-1:0] pinsOut
);

  logic [WIDTH-1:0] stage1Reg;

  // ---------------------------------------------------------------
  // Synchroniser chain
  // ---------------------------------------------------------------
  // Reset to all ones keeps idle-high pins from showing a false edge
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stage1Reg <= '1;
      pinsOut <= '1;
    end else begin
      stage1Reg <= pinsIn;
      pinsOut <= stage1Reg;
    end
  end

endmodule : qdac_pin_sync

// >>> qdac_ctrl.sv
/*
  Control logic of a quad 16-bit voltage-output converter: serial frame
  capture, input and output code registers, power modes, clear and load.
  Assumes the serial pins come from a host on another clock; clk samples them
  and runs at least a few times faster than the serial clock.
*/
// Notes on behaviour
// RQ1 - Frame is 32 bits: lead, command, address, data, tail; acts on 32nd fall. With chain enabled the code acts on select rising instead.
// RQ2 - Frame select high before the 32nd fall discards the frame, nothing changes.
// RQ3 - Setup command takes bit 1 as chain enable, bit 0 as reference enable.
// RQ4 - Power mode bits 9:8: normal, 1k to ground, 100k to ground, three-state.
// RQ5 - Power mode command applies only to channels whose select bits are set.
// RQ6 - Clear pin acts on its falling edge only, never on its level.
// RQ7 - Clear loads input and output registers of all channels with clear code.
// RQ8 - Clear code setting sits in bits 1:0 and resets to zero scale.
// RQ9 - Setting 00 gives 0x0000, 01 gives 0x8000, 10 gives 0xFFFF, 11 nothing.
// RQ10 - Command 0101 loads the clear code setting.
// RQ11 - Cleared state ends at the 32nd fall of the next valid frame. With chain enabled the code ends it on select rising instead.
// RQ12 - Clear during a frame aborts that frame without executing it.
// RQ13 - With load pin low, outputs update at the 32nd fall from new data. With chain enabled the code updates them on select rising instead.
// RQ14 - With load pin high, writes touch inputs; load falling edge copies them.
// RQ15 - Command 0011 writes the addressed input then updates all outputs.
// RQ16 - Mask bit 0 follows the load pin; mask bit 1 acts as pin held low.
// RQ17 - Command 0110 loads the four mask bits from bits 3:0; they reset to zero.
// RQ18 - Host shifts MSB first, stable at falling edges, select low all frame.
// RQ19 - Clear edge is resynchronised before it touches any register.
`timescale 1ns/1ps
module qdac_ctrl #(
  parameter int CHANNELS = 4,
  parameter int CODE_WIDTH = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic sclk,
  input wire logic syncN,
  input wire logic din,
  input wire logic asyncClearN,
  input wire logic loadOutputsN,
  output logic sdo,
  output logic [CHANNELS-1:0][CODE_WIDTH-1:0] dacCode,
  output logic [CHANNELS-1:0][1:0] powerMode,
  output logic chainEnable,
  output logic refEnable,
  output logic clearActive
);

  // ---------------------------------------------------------------
  // Pin synchronisation and edge detection
  // ---------------------------------------------------------------
  qdac_pkg::qdac_pins_s pinsRaw;
  qdac_pkg::qdac_pins_s pinsSync;
  qdac_pkg::qdac_pins_s pinsPrevReg;

  assign pinsRaw = '{sclk: sclk, syncN: syncN, din: din, asyncClearN: asyncClearN, loadOutputsN: loadOutputsN};

  // Both clear and load edges pass two flip-flops first  (see RQ19)
  qdac_pin_sync #(
    .WIDTH($bits(qdac_pkg::qdac_pins_s))
  ) u_pin_sync (
    .clk(clk),
    .reset(reset),
    .pinsIn(pinsRaw),
    .resetValue('1),
    .pinsOut(pinsSync)
  );

  // Previous synced values for edge detection
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pinsPrevReg <= '1;
    end else begin
      pinsPrevReg <= pinsSync;
    end
  end

  logic sclkFall;
  logic sclkRise;
  logic syncRise;
  logic clearEvt;
  logic loadFall;

  assign sclkFall = pinsPrevReg.sclk & ~pinsSync.sclk;
  assign sclkRise = ~pinsPrevReg.sclk & pinsSync.sclk;
  assign syncRise = ~pinsPrevReg.syncN & pinsSync.syncN;
  assign clearEvt = pinsPrevReg.asyncClearN & ~pinsSync.asyncClearN; // Edge only, level ignored  (see RQ6)
  assign loadFall = pinsPrevReg.loadOutputsN & ~pinsSync.loadOutputsN;

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------
  function automatic logic [3:0] chan_select(input logic [3:0] addr);
    chan_select = 4'h0;
    if (addr == qdac_pkg::ADDR_ALL) begin
      chan_select = 4'hf;
    end else if (addr[3:2] == 2'h0) begin
      chan_select = 4'h1 << addr[1:0];
    end
  endfunction : chan_select

  function automatic logic [15:0] clear_value(input logic [1:0] sel);
    case (sel)
      qdac_pkg::CLEAR_SEL_MID: clear_value = qdac_pkg::CODE_MID;
      qdac_pkg::CLEAR_SEL_FULL: clear_value = qdac_pkg::CODE_FULL;
      default: clear_value = qdac_pkg::CODE_ZERO;
    endcase
  endfunction : clear_value

  // ---------------------------------------------------------------
  // Frame capture
  // ---------------------------------------------------------------
  logic [31:0] shiftReg;
  logic [5:0] bitCountReg;
  logic abortReg;
  logic [31:0] shiftNext;
  logic frameActive;

  assign frameActive = ~pinsSync.syncN & ~abortReg;
  assign shiftNext = {shiftReg[30:0], pinsSync.din}; // MSB arrives first  (see RQ18)

  // Counter saturates at a full frame; leaving the frame clears it  (see RQ2)
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      shiftReg <= '0;
      bitCountReg <= '0;
    end else if (pinsSync.syncN) begin
      bitCountReg <= '0;
    end else if (sclkFall && frameActive) begin
      shiftReg <= shiftNext;
      if (bitCountReg != qdac_pkg::FRAME_FULL_COUNT) begin
        bitCountReg <= bitCountReg + 6'h01;
      end
    end
  end

  // A clear during a frame poisons it until select returns high  (see RQ12)
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      abortReg <= 1'b0;
    end else if (clearEvt && !pinsSync.syncN) begin
      abortReg <= 1'b1;
    end else if (pinsSync.syncN) begin
      abortReg <= 1'b0;
    end
  end

  // Standalone frames act on the 32nd fall; chained frames on select rising
  logic execValid;
  qdac_pkg::qdac_frame_s execFrame;
  logic [31:0] execBits;

  always_comb begin
    execValid = 1'b0;
    execBits = shiftNext;
    if (!chainEnable) begin
      execValid = sclkFall && frameActive && (bitCountReg == qdac_pkg::FRAME_LAST_INDEX); // see RQ1
    end else begin
      execBits = shiftReg;
      execValid = syncRise && !abortReg && (bitCountReg == qdac_pkg::FRAME_FULL_COUNT);
    end
    if (clearEvt) begin
      execValid = 1'b0; // see RQ12
    end
  end

  assign execFrame = execBits;

  logic [3:0] chanSel;
  logic isSoftReset;
  logic writesInput;

  assign chanSel = chan_select(execFrame.addr);
  assign isSoftReset = execValid && (execFrame.cmd == qdac_pkg::CMD_SOFT_RESET);
  assign writesInput = (execFrame.cmd == qdac_pkg::CMD_WRITE_INPUT) ||
                       (execFrame.cmd == qdac_pkg::CMD_WRITE_UPDATE_ONE) ||
                       (execFrame.cmd == qdac_pkg::CMD_WRITE_UPDATE_ALL);

  // Daisy-chain output changes on the rising serial edge
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sdo <= 1'b0;
    end else if (sclkRise && chainEnable && !pinsSync.syncN) begin
      sdo <= shiftReg[31];
    end
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  logic [3:0] updateMaskReg;
  logic [1:0] clearSelReg;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      updateMaskReg <= qdac_pkg::RESET_UPDATE_MASK;
      clearSelReg <= qdac_pkg::RESET_CLEAR_SEL; // Zero scale by default  (see RQ8)
      {chainEnable, refEnable} <= qdac_pkg::RESET_SETUP;
    end else if (isSoftReset) begin
      updateMaskReg <= qdac_pkg::RESET_UPDATE_MASK;
      clearSelReg <= qdac_pkg::RESET_CLEAR_SEL;
      {chainEnable, refEnable} <= qdac_pkg::RESET_SETUP;
    end else if (execValid) begin
      case (execFrame.cmd)
        qdac_pkg::CMD_LOAD_UPDATE_MASK: begin
          updateMaskReg <= execBits[qdac_pkg::CHAN_SEL_HI_POS:qdac_pkg::CHAN_SEL_LO_POS]; // see RQ17
        end
        qdac_pkg::CMD_LOAD_CLEAR_CODE: begin
          clearSelReg <= execBits[qdac_pkg::CLEAR_CODE_HI_POS:qdac_pkg::CLEAR_CODE_LO_POS]; // see RQ10
        end
        qdac_pkg::CMD_SETUP: begin
          chainEnable <= execBits[qdac_pkg::CHAIN_ENABLE_POS]; // see RQ3
          refEnable <= execBits[qdac_pkg::REF_ENABLE_POS];
        end
        default: begin
        end
      endcase
    end
  end

  // Power mode per channel, address field ignored  (see RQ4)
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      powerMode <= '0;
    end else if (isSoftReset) begin
      powerMode <= '0;
    end else if (execValid && execFrame.cmd == qdac_pkg::CMD_POWER_MODE) begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (execBits[qdac_pkg::CHAN_SEL_LO_POS + i]) begin
          powerMode[i] <= execBits[qdac_pkg::POWER_MODE_HI_POS:qdac_pkg::POWER_MODE_LO_POS]; // see RQ5
        end
      end
    end
  end

  // Cleared state: a new clear wins over leaving it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      clearActive <= 1'b0;
    end else if (clearEvt && clearSelReg != qdac_pkg::CLEAR_SEL_NOP) begin
      clearActive <= 1'b1;
    end else if (execValid) begin
      clearActive <= 1'b0; // see RQ11
    end
  end

  // ---------------------------------------------------------------
  // Input and output code registers
  // ---------------------------------------------------------------
  logic [CHANNELS-1:0][CODE_WIDTH-1:0] inputCodeReg;
  logic [CHANNELS-1:0] followsNow;
  logic clearLoads;

  // Channel counts as load-low if the pin is low or its mask overrides it
  assign followsNow = {CHANNELS{~pinsSync.loadOutputsN}} | updateMaskReg; // see RQ16
  assign clearLoads = clearEvt && (clearSelReg != qdac_pkg::CLEAR_SEL_NOP); // see RQ9

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      inputCodeReg <= '0;
    end else if (clearLoads) begin
      for (int i = 0; i < CHANNELS; i++) begin
        inputCodeReg[i] <= clear_value(clearSelReg); // see RQ7
      end
    end else if (isSoftReset) begin
      inputCodeReg <= '0;
    end else if (execValid && writesInput) begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (chanSel[i]) begin
          inputCodeReg[i] <= execFrame.data; // see RQ14
        end
      end
    end
  end

  // Output update: clear first, then frame effects, then the load pin edge
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dacCode <= '0;
    end else if (clearLoads) begin
      for (int i = 0; i < CHANNELS; i++) begin
        dacCode[i] <= clear_value(clearSelReg); // see RQ7
      end
    end else if (isSoftReset) begin
      for (int i = 0; i < CHANNELS; i++) begin
        dacCode[i] <= qdac_pkg::RESET_CODE;
      end
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (execValid && execFrame.cmd == qdac_pkg::CMD_WRITE_UPDATE_ALL) begin
          dacCode[i] <= chanSel[i] ? execFrame.data : inputCodeReg[i]; // see RQ15
        end else if (execValid && chanSel[i] && execFrame.cmd == qdac_pkg::CMD_WRITE_UPDATE_ONE) begin
          dacCode[i] <= execFrame.data;
        end else if (execValid && chanSel[i] && execFrame.cmd == qdac_pkg::CMD_UPDATE_DAC) begin
          dacCode[i] <= inputCodeReg[i];
        end else if (execValid && chanSel[i] && followsNow[i] && execFrame.cmd == qdac_pkg::CMD_WRITE_INPUT) begin
          dacCode[i] <= execFrame.data; // see RQ13
        end else if (loadFall && !updateMaskReg[i]) begin
          dacCode[i] <= inputCodeReg[i]; // see RQ14
        end
      end
    end
  end

endmodule : qdac_ctrl

// >>> qdac_ctrl_checker.sv
/* Port assertions for qdac_ctrl, bound to every instance.
   Assumes one clk domain and serial, clear and load pins that idle high. */
`timescale 1ns/1ps
module qdac_ctrl_checker #(
  parameter int CHANNELS = 4,
  parameter int CODE_WIDTH = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic sclk,
  input wire logic syncN,
  input wire logic din,
  input wire logic asyncClearN,
  input wire logic loadOutputsN,
  input wire logic sdo,
  input wire logic [CHANNELS-1:0][CODE_WIDTH-1:0] dacCode,
  input wire logic [CHANNELS-1:0][1:0] powerMode,
  input wire logic chainEnable,
  input wire logic refEnable,
  input wire logic clearActive
);
  // -------
  // Cycles since pin edges; saturating so idle time reads as old
  // -------
  logic [3:0] pinReg;
  logic [3:0] linkAge;
  logic [3:0] clrAge;
  logic [3:0] ldAge;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pinReg <= 4'hf;
      linkAge <= 4'hf;
      clrAge <= 4'hf;
      ldAge <= 4'hf;
    end else begin
      pinReg <= {sclk, syncN, asyncClearN, loadOutputsN};
      linkAge <= (pinReg[3] & ~sclk) | (~pinReg[2] & syncN) ? 4'h0 : linkAge + {3'h0, linkAge != 4'hf};
      clrAge <= pinReg[1] & ~asyncClearN ? 4'h0 : clrAge + {3'h0, clrAge != 4'hf};
      ldAge <= pinReg[0] & ~loadOutputsN ? 4'h0 : ldAge + {3'h0, ldAge != 4'hf};
    end
  end
  // Every effect trails its own pin edge by the synchroniser delay only
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_clear_after_fall: assert property ($rose(clearActive) |-> clrAge >= 4'h1 && clrAge <= 4'h6)
    else $error("clear flag rose without a clear edge");
  a_clear_code_all: assert property ($rose(clearActive) |-> dacCode[1] == dacCode[0] &&
    dacCode[2] == dacCode[0] && dacCode[3] == dacCode[0] && dacCode[0] inside {16'h0000, 16'h8000, 16'hffff})
    else $error("clear code not loaded on all channels");
  a_clear_ends_frame: assert property ($fell(clearActive) |-> linkAge <= 4'h6)
    else $error("clear flag dropped without a frame");
  a_cfg_from_frame: assert property (!$stable({powerMode, chainEnable, refEnable}) |-> linkAge <= 4'h6)
    else $error("setup changed without a frame");
  a_code_has_cause: assert property (!$stable(dacCode) |-> linkAge <= 4'h6 || clrAge <= 4'h6 || ldAge <= 4'h6)
    else $error("output code changed without a cause");
  a_setup_alone: assert property (!$stable({chainEnable, refEnable}) |-> $stable(dacCode) || dacCode == '0)
    else $error("setup command moved output codes");
  a_mode_keeps_code: assert property (!$stable(powerMode) |-> $stable(dacCode) || dacCode == '0)
    else $error("power mode command moved output codes");
  a_sdo_idle: assert property (syncN [*6] |=> $stable(sdo))
    else $error("chain output moved while deselected");
  c_clear: cover property ($rose(clearActive));
  c_load: cover property (ldAge == 4'h2);
  c_mode: cover property (!$stable(powerMode));
  c_chain: cover property ($rose(chainEnable));
endmodule : qdac_ctrl_checker

bind qdac_ctrl qdac_ctrl_checker #(.CHANNELS(CHANNELS), .CODE_WIDTH(CODE_WIDTH)) chk_u (.clk(clk), .reset(reset),
  .sclk(sclk), .syncN(syncN), .din(din), .asyncClearN(asyncClearN), .loadOutputsN(loadOutputsN), .sdo(sdo),
  .dacCode(dacCode), .powerMode(powerMode), .chainEnable(chainEnable), .refEnable(refEnable),
  .clearActive(clearActive));

// >>> qdac_host_model.sv
/* Host serial master model: sends frames MSB first on a gated clock.
   Assumes the caller picks the half period, 80 ns for the bench rate. */
`timescale 1ns/1ps
module qdac_host_model (
  output logic sclk,
  output logic syncN,
  output logic din
);
  // Idle: clock parked high, frame select high
  initial begin
    sclk = 1'h1;
    syncN = 1'h1;
    din = 1'h0;
  end
  // Sends the first n bits of f; n below 32 gives a cut-short frame
  task automatic send(input logic [31:0] f, input int n, input int h = 80);
    syncN = 1'h0;
    for (int i = 31; i > 31 - n; i--) begin
      sclk = 1'h1;
      din = f[i];
      #(h);
      sclk = 1'h0;
      #(h);
    end
    sclk = 1'h1;
    #(h);
    syncN = 1'h1;
    din = ~din; // Released line must not keep showing the last bit
  endtask : send
endmodule : qdac_host_model

// >>> quad_dac_update_clear_powerdown_ctrl_tb.sv
/* Self-checking bench for qdac_ctrl against a behavioural model.
   Assumes qdac_host_model drives the serial pins and the checker is bound. */
`timescale 1ns/1ps
module quad_dac_update_clear_powerdown_ctrl_tb;
  logic clk, reset, asyncClearN, loadOutputsN, sclk, syncN, din, sdo;
  logic [3:0][15:0] dacCode;
  logic [3:0][1:0] powerMode;
  logic chainEnable, refEnable, clearActive;
  int n_fail, n_tests;
  int inR[4], dacR[4], pm[4];
  int mask, csel, chn, rf, clrA, sdoM;

  qdac_host_model host_u (.sclk(sclk), .syncN(syncN), .din(din));
  qdac_ctrl dut_u (.clk(clk), .reset(reset), .sclk(sclk), .syncN(syncN), .din(din), .asyncClearN(asyncClearN),
    .loadOutputsN(loadOutputsN), .sdo(sdo), .dacCode(dacCode), .powerMode(powerMode), .chainEnable(chainEnable),
    .refEnable(refEnable), .clearActive(clearActive));

  // 50 MHz system clock
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  // -------
  // Reporting and comparison against the model
  // -------
  task automatic fail(input string m);
    n_fail++;
    $display("FAIL %0t %s", $time, m);
  endtask : fail
  task automatic chk();
    n_tests++;
    for (int i = 0; i < 4; i++) if (dacCode[i] !== 16'(dacR[i]) || powerMode[i] !== 2'(pm[i])) fail("channel mismatch");
    if ({chainEnable, refEnable, clearActive} !== {1'(chn), 1'(rf), 1'(clrA)}) fail("setup or clear flag mismatch");
    if (sdo !== 1'(sdoM)) fail("chain output mismatch");
  endtask : chk
  task automatic complete_run();
    if (n_fail == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run

  // -------
  // Model of one executed frame, with frame stimulus helpers
  // -------
  task automatic exec(input logic [31:0] f);
    int c;
    int a;
    c = f[27:24];
    a = f[23:20];
    clrA = 0;
    for (int i = 0; i < 4; i++) begin
      if (a == i || a == 15) begin
        if (c == 0 || c == 2 || c == 3) inR[i] = f[19:4];
        if (c == 1 || c == 2 || (c == 0 && (!loadOutputsN || mask[i]))) dacR[i] = inR[i];
      end
      if (c == 3) dacR[i] = inR[i];
      if (c == 4 && f[i]) pm[i] = f[9:8];
    end
    if (c == 5) csel = f[1:0];
    if (c == 6) mask = f[3:0];
    if (c == 8) chn = f[1];
    if (c == 8) rf = f[0];
    // Soft reset returns codes, modes, mask, clear setting and setup to their values after reset; the chain output keeps its value
    if (c == 7) begin
      mask = 0;
      csel = 0;
      chn = 0;
      rf = 0;
      for (int i = 0; i < 4; i++) begin
        inR[i] = 0;
        dacR[i] = 0;
        pm[i] = 0;
      end
    end
  endtask : exec
  function automatic logic [31:0] fr(input int c, input int a, input int x);
    return {4'($urandom), 4'(c), 4'(a), 20'(x)};
  endfunction : fr
  // Channel 0..3 or the all-channels address
  function automatic int rA();
    int a;
    a = $urandom % 5;
    return a == 4 ? 15 : a;
  endfunction : rA
  task automatic frm(input logic [31:0] f, input int n);
    int c0;
    c0 = chn;
    host_u.send(f, n);
    if (n == 32) exec(f);
    // After a full chained frame the last rising edge shows its first bit; it holds while deselected
    if (n == 32 && (c0 || chn)) sdoM = f[31];
    repeat (10) @(negedge clk);
    chk();
  endtask : frm
  // Load pin pulse: only channels left to the pin copy input to output
  task automatic ld();
    @(negedge clk) loadOutputsN = 1'h0;
    for (int i = 0; i < 4; i++) if (!mask[i]) dacR[i] = inR[i];
    repeat (10) @(negedge clk);
    chk();
    loadOutputsN = 1'h1;
  endtask : ld
  // Clear edge; with h set, a frame goes in while the pin is still low
  task automatic clr(input int h);
    int c;
    c = csel == 0 ? 0 : csel == 1 ? 'h8000 : 'hffff;
    @(negedge clk) asyncClearN = 1'h0;
    if (csel != 3) clrA = 1;
    for (int i = 0; i < 4; i++) if (csel != 3) {inR[i], dacR[i]} = {c, c};
    if (h) begin
      repeat (10) @(negedge clk);
      chk();
      frm(fr(0, rA(), $urandom), 32);
    end
    @(negedge clk) asyncClearN = 1'h1;
  endtask : clr

  // Watchdog: the sequence needs well under half of this span
  initial begin
    #1000000;
    n_fail++;
    complete_run();
  end

  // Main sequence
  initial begin
    void'($urandom(32'h10818b53));
    {reset, asyncClearN, loadOutputsN} = 3'h6;
    repeat (8) @(negedge clk);
    reset = 1'h0;
    repeat (4) @(negedge clk);
    chk();
    clr(1);
    repeat (10) frm(fr($urandom % 4, rA(), $urandom), 32);
    loadOutputsN = 1'h1;
    repeat (6) frm(fr($urandom % 4, rA(), $urandom), 32);
    ld();
    frm(fr(6, 0, $urandom), 32);
    repeat (6) frm(fr($urandom % 4, rA(), $urandom), 32);
    ld();
    for (int m = 0; m < 4; m++) frm(fr(4, $urandom, (m << 8) | ($urandom % 16)), 32);
    for (int s = 3; s >= 0; s--) frm(fr(8, 0, s), 32);
    frm(fr(0, 15, $urandom), 31);
    frm(fr(5, 0, 2), 17);
    for (int s = 0; s < 4; s++) begin
      frm(fr(5, 0, s), 32);
      clr(1);
    end
    fork
      host_u.send(fr(2, 15, $urandom), 32, 120);
      begin
        repeat (60) @(negedge clk);
        clr(0);
      end
    join
    repeat (10) @(negedge clk);
    chk();
    frm(fr(3, rA(), $urandom), 32);
    frm(fr(7, 0, $urandom), 32);
    complete_run();
  end
endmodule : quad_dac_update_clear_powerdown_ctrl_tb
